//--- core/pwm16.v
`include "pwm16_regs.vh"
`default_nettype none
module pwm16 (
  input  wire        CLK,      // 125 MHz clock
  input  wire        RESETN,   // synchronous reset, active low
  input  wire [3:0]  ADDR,     // register address
  input  wire [15:0] WDATA,    // write data
  input  wire        WR,       // write strobe
  input  wire        RD,       // read strobe
  output reg  [15:0] RDATA,    // read data, cycle after RD
  output wire [1:0]  PIN_OUT,  // pin level, A in bit 0
  output wire [1:0]  PIN_OE    // pin drive enable, A in bit 0
);

  // ****************************************
  // registers
  // ****************************************
  reg  [15:0] ctrl_q;
  reg  [15:0] count_q;
  reg  [15:0] cap_top_q;
  reg  [3:0]  flags_q;
  reg  [1:0]  dir_q;
  reg         down_q;
  reg  [9:0]  pre_q;
  reg  [15:0] cmp_act_q [0:1];
  reg  [15:0] cmp_buf_q [0:1];
  reg  [1:0]  out_q;

  wire [3:0]  wgm   = ctrl_q[`CTRL_WGM_MSB:`CTRL_WGM_LSB];
  wire [2:0]  csel  = ctrl_q[`CTRL_CS_MSB:`CTRL_CS_LSB];
  wire [1:0]  com_a = ctrl_q[`CTRL_COMA_MSB:`CTRL_COMA_LSB];
  wire [1:0]  com_b = ctrl_q[`CTRL_COMB_MSB:`CTRL_COMB_LSB];

  wire fast  = (wgm == 4'h5) || (wgm == 4'h6) || (wgm == 4'h7) ||
               (wgm == 4'hE) || (wgm == 4'hF);
  wire phase = (wgm == 4'h1) || (wgm == 4'h2) || (wgm == 4'h3) ||
               (wgm == 4'hA) || (wgm == 4'hB);
  wire top_is_cap = (wgm == 4'hE) || (wgm == 4'hA);
  wire top_is_a   = (wgm == 4'hF) || (wgm == 4'hB);

  // ****************************************
  // prescaler
  // ****************************************
  reg       tick;
  always @* begin
    case (csel)
      3'h1:    tick = 1'b1;
      3'h2:    tick = (pre_q[2:0] == `DIV_8);
      3'h3:    tick = (pre_q[5:0] == `DIV_64);
      3'h4:    tick = (pre_q[7:0] == `DIV_256);
      3'h5:    tick = (pre_q == `DIV_1024);
      default: tick = 1'b0;
    endcase
  end

  always @(posedge CLK) begin
    if (!RESETN || csel == 3'h0) begin
      pre_q <= 10'h000;
    end else begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // ****************************************
  // top selection and masking
  // ****************************************
  reg  [15:0] top;
  always @* begin
    case (wgm)
      4'h1, 4'h5: top = `TOP_8BIT;
      4'h2, 4'h6: top = `TOP_9BIT;
      4'h3, 4'h7: top = `TOP_10BIT;
      4'hA, 4'hE: top = cap_top_q;
      4'hB, 4'hF: top = cmp_act_q[0];
      default:    top = `VAL_MAX;
    endcase
  end

  // fixed modes trim written compare data; other modes keep all bits
  wire        fixed   = (wgm[1:0] != 2'b00) && (wgm[3:2] == 2'b00 || wgm[3:2] == 2'b01);
  wire [15:0] wmask   = fixed ? top : `VAL_MAX;
  wire        pwm     = fast || phase;
  wire        at_top  = (count_q == top);
  wire        at_zero = (count_q == `VAL_RESET);
  // compares buffered in the PWM modes, live otherwise
  wire        load    = tick && at_top && pwm;

  // ****************************************
  // counter and direction
  // ****************************************
  always @(posedge CLK) begin
    if (!RESETN) begin
      count_q <= `VAL_RESET;
      down_q  <= 1'b0;
    end else if (WR && ADDR == `ADDR_COUNT) begin
      count_q <= WDATA;
    end else if (tick) begin
      if (phase) begin
        if (at_top) begin
          down_q  <= 1'b1;
          count_q <= count_q - 16'h0001;
        end else if (down_q && at_zero) begin
          down_q  <= 1'b0;
          count_q <= count_q + 16'h0001;
        end else if (down_q) begin
          count_q <= count_q - 16'h0001;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end else begin
        down_q <= 1'b0;
        // a top below the count is missed and the count wraps
        if (fast && at_top) begin
          count_q <= `VAL_RESET;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************
  // compare channels
  // ****************************************
  wire [1:0] match;
  wire [1:0] nxt_out;
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : chan
      wire [1:0] com = (i == 0) ? com_a : com_b;
      reg        o;
      assign match[i] = (count_q == cmp_act_q[i]);
      always @* begin
        o = out_q[i];
        // mode field read live, so a change acts at the next match
        if (fast) begin
          if (match[i] && !at_top) begin
            if (com == 2'h2) o = 1'b0;
            else if (com == 2'h3) o = 1'b1;
            else if (com == 2'h1 && i == 0) o = ~out_q[i];
          end else if (match[i] && at_top) begin
            // compare equal to top: the bottom action wins and set/clear levels stay constant; A in toggle mode still flips
            if (com == 2'h2) o = 1'b1;
            else if (com == 2'h3) o = 1'b0;
            else if (com == 2'h1 && i == 0) o = ~out_q[i];
          end else if (at_top) begin
            if (com == 2'h2) o = 1'b1;
            else if (com == 2'h3) o = 1'b0;
          end
        end else if (phase && match[i]) begin
          // at zero or top, a constant level is picked whatever the direction
          if (com == 2'h2) o = (at_zero ? 1'b0 : (at_top ? 1'b1 : down_q));
          else if (com == 2'h3) o = (at_zero ? 1'b1 : (at_top ? 1'b0 : ~down_q));
        end
      end
      assign nxt_out[i] = o;

      always @(posedge CLK) begin
        if (!RESETN) begin
          cmp_act_q[i] <= `VAL_RESET;
          cmp_buf_q[i] <= `VAL_RESET;
          out_q[i]     <= 1'b0;
        end else begin
          if (WR && ADDR == ((i == 0) ? `ADDR_CMP_A : `ADDR_CMP_B)) begin
            cmp_buf_q[i] <= WDATA & wmask;
            if (!pwm) cmp_act_q[i] <= WDATA & wmask;
          end
          if (load) cmp_act_q[i] <= cmp_buf_q[i];
          if (tick && pwm) out_q[i] <= nxt_out[i];
        end
      end

      assign PIN_OE[i]  = dir_q[i] && (com != 2'h0);
      assign PIN_OUT[i] = out_q[i];
    end
  endgenerate

  // ****************************************
  // flags, control and readback
  // ****************************************
  wire [3:0] set;
  assign set[`FLG_OVF]  = tick && ((fast && at_top) ||
                                   (phase && down_q && at_zero));
  assign set[`FLG_CMPA] = tick && (match[0] || (pwm && top_is_a && at_top));
  assign set[`FLG_CMPB] = tick && match[1];
  assign set[`FLG_CAP]  = tick && pwm && top_is_cap && at_top;

  always @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q    <= `CTRL_RESET;
      cap_top_q <= `VAL_RESET;
      flags_q   <= 4'h0;
      dir_q     <= 2'h0;
      RDATA     <= 16'h0000;
    end else begin
      if (WR && ADDR == `ADDR_CTRL)    ctrl_q    <= WDATA;
      if (WR && ADDR == `ADDR_CAP_TOP) cap_top_q <= WDATA;
      if (WR && ADDR == `ADDR_DIR)     dir_q     <= WDATA[1:0];
      // write one to clear; a same-cycle set wins
      if (WR && ADDR == `ADDR_FLAGS) flags_q <= (flags_q & ~WDATA[3:0]) | set;
      else                           flags_q <= flags_q | set;
      if (RD) begin
        case (ADDR)
          `ADDR_CTRL:    RDATA <= ctrl_q;
          `ADDR_COUNT:   RDATA <= count_q;
          `ADDR_CMP_A:   RDATA <= cmp_act_q[0];
          `ADDR_CMP_B:   RDATA <= cmp_act_q[1];
          `ADDR_CAP_TOP: RDATA <= cap_top_q;
          `ADDR_FLAGS:   RDATA <= {10'h000, down_q, |out_q, flags_q};
          `ADDR_DIR:     RDATA <= {14'h0000, dir_q};
          default:       RDATA <= 16'h0000;
        endcase
      end else begin
        RDATA <= 16'h0000;
      end
    end
  end

endmodule
`default_nettype wire

//--- core/pwm16_regs.vh
`ifndef PWM16_REGS_VH
`define PWM16_REGS_VH
// register addresses on the plain port
`define ADDR_CTRL        4'h0
`define ADDR_COUNT       4'h1
`define ADDR_CMP_A       4'h2
`define ADDR_CMP_B       4'h3
`define ADDR_CAP_TOP     4'h4
`define ADDR_FLAGS       4'h5
`define ADDR_DIR         4'h6
// control field positions
`define CTRL_WGM_LSB     0
`define CTRL_WGM_MSB     3
`define CTRL_CS_LSB      4
`define CTRL_CS_MSB      6
`define CTRL_COMA_LSB    8
`define CTRL_COMA_MSB    9
`define CTRL_COMB_LSB    10
`define CTRL_COMB_MSB    11
// flag bit positions
`define FLG_OVF          0
`define FLG_CMPA         1
`define FLG_CMPB         2
`define FLG_CAP          3
// reset values
`define CTRL_RESET       16'h0000
`define VAL_RESET        16'h0000
// fixed tops
`define TOP_8BIT         16'h00FF
`define TOP_9BIT         16'h01FF
`define TOP_10BIT        16'h03FF
`define VAL_MAX          16'hFFFF
// prescaler divisions
`define DIV_8            10'h007
`define DIV_64           10'h03F
`define DIV_256          10'h0FF
`define DIV_1024         10'h3FF
`endif

//--- test/pwm16_chk.sv
`include "pwm16_regs.vh"
`default_nettype none
// ****************
// port checker
// ****************
module pwm16_chk (
  input wire logic        CLK,     // clock
  input wire logic        RESETN,  // reset, low
  input wire logic [3:0]  ADDR,    // address
  input wire logic [15:0] WDATA,   // write data
  input wire logic        WR,      // write strobe
  input wire logic        RD,      // read strobe
  input wire logic [15:0] RDATA,   // read data
  input wire logic [1:0]  PIN_OUT, // pin level
  input wire logic [1:0]  PIN_OE   // pin enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctrl_q;
  logic [1:0]  dir_q;
  logic        fast;
  assign fast = ctrl_q[3:0] inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
  always @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q <= `CTRL_RESET;
      dir_q <= 2'h0;
    end else if (WR && ADDR == `ADDR_CTRL) begin
      ctrl_q <= WDATA;
    end else if (WR && ADDR == `ADDR_DIR) begin
      dir_q <= WDATA[1:0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  a_reset_out: assert property (disable iff (1'b0) !RESETN |=> PIN_OUT == 2'h0)
    else $error("outputs not cleared by reset");
  a_pin_enable: assert property (PIN_OE == {dir_q[1] && ctrl_q[11:10] != 2'h0,
    dir_q[0] && ctrl_q[9:8] != 2'h0}) else $error("pin enable wrong");
  a_oe_rise: assert property ($rose(PIN_OE[0]) |-> $past(WR))
    else $error("pin enable rose without a write");
  a_stop_hold: assert property (ctrl_q[6:4] == 3'h0 && $past(ctrl_q[6:4]) == 3'h0
    |-> $stable(PIN_OUT)) else $error("output moved while stopped");
  a_fast_up: assert property ($past(RD && ADDR == `ADDR_FLAGS && fast) |-> !RDATA[5])
    else $error("down state seen in single slope");
  a_dir_read: assert property ($past(RD && ADDR == `ADDR_DIR)
    |-> RDATA[1:0] == $past(dir_q)) else $error("direction read wrong");
  a_cap_read: assert property ((WR && ADDR == `ADDR_CAP_TOP) ##1
    (RD && ADDR == `ADDR_CAP_TOP) |=> RDATA == $past(WDATA, 2)) else $error("top not at once");
  a_rd_quiet: assert property (!$past(RD) |-> RDATA == 16'h0000)
    else $error("read data outside read slot");
endmodule
`default_nettype wire

//--- test/pwm16_pad.sv
`default_nettype none
// ****************
// pin pad model
// ****************
module pwm16_pad (
  input  wire logic       clk,     // clock
  input  wire logic [1:0] pin_out, // level
  input  wire logic [1:0] pin_oe,  // enable
  output var  logic [1:0] pad      // pad level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_q = 2'h0;
  always @(posedge clk) last_q <= pad;
  // a floating pad flips each cycle, so a stale level never passes
  always_comb pad = (pin_oe & pin_out) | (~pin_oe & ~last_q);
endmodule
`default_nettype wire

//--- test/timer16_fast_and_phase_pwm_tb.sv
`include "pwm16_regs.vh"
`default_nettype none
// ****************
// stimulus and scoring
// ****************
module timer16_fast_and_phase_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  wire  [15:0] rdata;
  wire  [1:0]  pin_out;
  wire  [1:0]  pin_oe;
  wire  [1:0]  pad;
  int          mismatches = 0;
  int          total_checks = 0;
  logic [3:0]  modes [12] = '{4'h5, 4'h6, 4'h7, 4'hE, 4'hF, 4'h1, 4'h2, 4'h3, 4'hA, 4'hB,
                              4'h5, 4'h7};
  initial forever #4 clk = ~clk;
  pwm16 DUT (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PIN_OUT(pin_out), .PIN_OE(pin_oe));
  pwm16_pad u_pad (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // optional write, then optional read expecting d; flags compare in the low nibble only
  task automatic acc(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    if (w) begin
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
    if (r) begin
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("read", rdata & ((a == `ADDR_FLAGS) ? 16'h000F : 16'hFFFF), d);
    end
  endtask
  // high cycles of a non-inverted channel over two periods
  function automatic int hi(input logic dual, input int c, input int div);
    return dual ? 4 * c * div : 2 * (c + 1) * div;
  endfunction
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    int m, cs, ca, cb, top, div, win, ea, ha, hb, coma;
    logic dual, cap;
    logic [15:0] junk;
    void'($urandom(36326));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    #1 chk("reset pins", {12'h000, pin_oe, pin_out}, 16'h0000);
    acc(1'b1, 1'b1, `ADDR_CAP_TOP, 16'($urandom_range(3, 65535)));
    acc(1'b1, 1'b1, `ADDR_DIR, 16'h0002);
    for (int a = 7; a < 16; a++) begin
      acc(1'b1, 1'b0, 4'(a), 16'($urandom));
      acc(1'b0, 1'b1, 4'(a), 16'h0000);
    end
    for (int k = 0; k < 12; k++) begin
      m = modes[k];
      div = (k == 10) ? 8 : 1;
      cs = (k == 10) ? 2 : 1;
      coma = (k == 4) ? 1 : (k >= 10) ? 3 : 2;
      dual = m < 12 && !(m inside {5, 6, 7});
      cap = m == 10 || m == 14;
      top = (m >= 8) ? $urandom_range(3, 300) : (256 << (m % 4 - 1)) - 1;
      ca = (m == 11 || m == 15 || k % 3 == 2) ? top : (k % 3 == 0) ? 0 : $urandom_range(0, top);
      cb = $urandom_range(0, top);
      junk = (m < 8) ? 16'($urandom) & ~16'(top) : 16'h0000;
      win = 2 * (dual ? 2 * top : top + 1) * div;
      ea = (k == 4) ? win / 2 : hi(dual, ca, div);
      if (k >= 10) ea = win - ea;
      acc(1'b1, 1'b0, `ADDR_CTRL, `CTRL_RESET);
      acc(1'b1, 1'b0, `ADDR_COUNT, `VAL_RESET);
      acc(1'b1, 1'b0, `ADDR_CAP_TOP, cap ? 16'(top) : `VAL_MAX);
      acc(1'b1, 1'b0, `ADDR_CTRL, {12'h000, 4'(m)});
      acc(1'b1, 1'b0, `ADDR_CMP_A, 16'(ca) | junk);
      acc(1'b1, 1'b0, `ADDR_CMP_B, 16'(cb) | junk);
      acc(1'b1, 1'b0, `ADDR_DIR, 16'h0003);
      acc(1'b1, 1'b0, `ADDR_CTRL, {4'h0, 2'h3, 2'(coma), 1'b0, 3'(cs), 4'(m)});
      repeat (win + 2100) @(posedge clk);
      acc(1'b1, 1'b0, `ADDR_FLAGS, 16'h000F);
      ha = 0;
      hb = 0;
      repeat (win) begin
        @(posedge clk);
        #1 ha += (pad[0] === 1'b1);
        hb += (pad[1] === 1'b1);
      end
      chk("high time A", 16'(ha), 16'(ea));
      chk("high time B", 16'(hb), 16'(win - hi(dual, cb, div)));
      acc(1'b0, 1'b1, `ADDR_FLAGS, {12'h000, cap, 3'h7});
    end
    acc(1'b1, 1'b0, `ADDR_DIR, 16'h0000);
    #1 chk("pin enable", {14'h0000, pin_oe}, 16'h0000);
    finish_test();
  end
endmodule
bind pwm16 pwm16_chk u_chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));
`default_nettype wire
